/* design/pfs_pkg.sv */
// Constants for the port E upper pin function select block.
// Assumes a 16-bit register port and eight muxed pins, pins 16 to 23.
package pfs_pkg;

   // Register port geometry.
   localparam int ADDR_W = 8;
   localparam int REG_W = 16;
   localparam int FIELD_W = 2;
   localparam int NUM_PINS = 8;

   // Offset of the function select register on the register port.
   localparam logic [7:0] FUNC_SEL_B_OFFSET = 8'h00;

   // Reset values: all fields select port I/O, or host-port data on host boot.
   localparam logic [15:0] FUNC_SEL_B_RESET_NORMAL = 16'h0000;
   localparam logic [15:0] FUNC_SEL_B_RESET_HOST_BOOT = 16'h5555;

   // Read value of an unmapped address.
   localparam logic [15:0] UNMAPPED_READ = 16'h0000;

   // Route codes held in each 2-bit field.
   localparam logic [1:0] ROUTE_GPIO = 2'h0;
   localparam logic [1:0] ROUTE_HOST_PORT = 2'h1;
   localparam logic [1:0] ROUTE_SERIAL = 2'h2;
   localparam logic [1:0] ROUTE_EXT_BUS = 2'h3;

   // Direction of the serial unit signal on each pin.
   localparam logic [1:0] SER_DIR_IN = 2'h0;
   localparam logic [1:0] SER_DIR_OUT = 2'h1;
   localparam logic [1:0] SER_DIR_BIDIR = 2'h2;

   // Two bits per pin, pin 16 in bits 1:0 up to pin 23 in bits 15:14.
   localparam logic [15:0] SER_DIR_MAP = 16'h0658;

endpackage : pfs_pkg

/* design/pfs_pin_route.sv */
// One muxed pin: steers the pad to one of four functions by a 2-bit code.
// Assumes each function supplies its own output and enable; pad input is synchronous.
`timescale 1ns/10ps
module pfs_pin_route #(
   parameter logic [1:0] SER_DIR = pfs_pkg::SER_DIR_IN
)
(
   input wire logic [1:0] route,
   input wire logic pad_in,
   output logic pad_out,
   output logic pad_oe,
   input wire logic gpio_out,
   input wire logic gpio_oe,
   output logic gpio_in,
   input wire logic host_out,
   input wire logic host_oe,
   output logic host_in,
   input wire logic ser_out,
   input wire logic ser_oe,
   output logic ser_in,
   input wire logic ebus_out,
   input wire logic ebus_oe,
   output logic ebus_in
);

   ////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      pad_out = 1'b0;
      pad_oe = 1'b0;
      gpio_in = 1'b0;
      host_in = 1'b0;
      ser_in = 1'b0;
      ebus_in = 1'b0;
      unique case (route)
         pfs_pkg::ROUTE_GPIO:
         begin
            pad_out = gpio_out;
            pad_oe = gpio_oe;
            gpio_in = pad_in;
         end
         pfs_pkg::ROUTE_HOST_PORT:
         begin
            pad_out = host_out;
            pad_oe = host_oe;
            host_in = pad_in;
         end
         pfs_pkg::ROUTE_SERIAL:
         begin
            // A fixed-direction serial signal ignores the unit's own enable.
            pad_out = ser_out;
            if (SER_DIR == pfs_pkg::SER_DIR_OUT)
            begin
               pad_oe = 1'b1;
            end
            else if (SER_DIR == pfs_pkg::SER_DIR_BIDIR)
            begin
               pad_oe = ser_oe;
            end
            else
            begin
               pad_oe = 1'b0;
            end
            ser_in = (SER_DIR == pfs_pkg::SER_DIR_OUT) ? 1'b0 : pad_in;
         end
         pfs_pkg::ROUTE_EXT_BUS:
         begin
            pad_out = ebus_out;
            pad_oe = ebus_oe;
            ebus_in = pad_in;
         end
      endcase
   end

endmodule : pfs_pin_route

/* design/pfs_port_e_upper_mux.sv */
// Function select register and pin mux for port E pins 16 to 23.
// Assumes a plain register port, a boot-mode level stable around reset,
// and peripherals that drive their own output and enable per pin.
//
// How it works
// R1 - A 16-bit read/write register chooses the function of the eight muxed pins.
// R2 - Bits 15:14 route pin 23: port I/O, host data 14, ch1 request-to-send in, bus data 30.
// R3 - Bits 13:12 route pin 22: port I/O, host data 13, ch0 clear-to-send in, bus data 29.
// R4 - Bits 11:10 route pin 21: port I/O, host data 12, ch0 request-to-send out, bus data 28.
// R5 - Bits 9:8 route pin 20: port I/O, host data 11, ch1 serial clock both ways, bus data 27.
// R6 - Bits 7:6 route pin 19: port I/O, host data 10, ch1 receive as output, bus data 26.
// R7 - Bits 5:4 route pin 18: port I/O, host data 9, ch1 transmit out, bus data 25.
// R8 - Bits 3:2 route pin 17: port I/O, host data 8, ch0 serial clock both ways, bus data 24.
// R9 - Bits 1:0 route pin 16: port I/O, host data 7, ch0 receive in, bus data 23.
// R10 - Reset clears upper field bits and sets lower ones only on host-port boot.
// R11 - A write steers the pins from the next cycle and a read returns the stored fields.
//
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/10ps
module pfs_port_e_upper_mux #(
   parameter int NUM_PINS = pfs_pkg::NUM_PINS
)
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic host_boot,
   input wire logic [pfs_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [pfs_pkg::REG_W-1:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [pfs_pkg::REG_W-1:0] reg_rdata,
   output logic [pfs_pkg::REG_W-1:0] pin_route,
   input wire logic [NUM_PINS-1:0] pad_in,
   output logic [NUM_PINS-1:0] pad_out,
   output logic [NUM_PINS-1:0] pad_oe,
   input wire logic [NUM_PINS-1:0] gpio_out,
   input wire logic [NUM_PINS-1:0] gpio_oe,
   output logic [NUM_PINS-1:0] gpio_in,
   input wire logic [NUM_PINS-1:0] host_port_out,
   input wire logic [NUM_PINS-1:0] host_port_oe,
   output logic [NUM_PINS-1:0] host_port_in,
   input wire logic [NUM_PINS-1:0] serial_out,
   input wire logic [NUM_PINS-1:0] serial_oe,
   output logic [NUM_PINS-1:0] serial_in,
   input wire logic [NUM_PINS-1:0] ext_bus_out,
   input wire logic [NUM_PINS-1:0] ext_bus_oe,
   output logic [NUM_PINS-1:0] ext_bus_in
);

   ////////////////////////////////////////////////////////////////////////////
   // Register port.

   logic [pfs_pkg::REG_W-1:0] port_e_upper_function_select_b;
   logic [pfs_pkg::REG_W-1:0] next_port_e_upper_function_select_b;
   logic [pfs_pkg::REG_W-1:0] next_reg_rdata;
   logic hit;

   function automatic logic [1:0] field_of(input logic [15:0] value, input int idx);
      field_of = value[idx*pfs_pkg::FIELD_W +: pfs_pkg::FIELD_W];
   endfunction : field_of

   always_comb
   begin
      hit = (reg_addr == pfs_pkg::FUNC_SEL_B_OFFSET);
      next_port_e_upper_function_select_b = port_e_upper_function_select_b;
      next_reg_rdata = pfs_pkg::UNMAPPED_READ;
      if (reset)
      begin
         // Host-port boot hands every pin to the host port data lane.
         if (host_boot)
         begin
            next_port_e_upper_function_select_b = pfs_pkg::FUNC_SEL_B_RESET_HOST_BOOT; // [R10]
         end
         else
         begin
            next_port_e_upper_function_select_b = pfs_pkg::FUNC_SEL_B_RESET_NORMAL; // [R10]
         end
      end
      else
      begin
         if (reg_write && hit)
         begin
            next_port_e_upper_function_select_b = reg_wdata; // [R1] [R11]
         end
         if (reg_read && hit)
         begin
            next_reg_rdata = port_e_upper_function_select_b; // [R1] [R11]
         end
      end
   end

   always_ff @(posedge core_clk)
   begin
      port_e_upper_function_select_b <= next_port_e_upper_function_select_b;
      reg_rdata <= next_reg_rdata;
   end

   assign pin_route = port_e_upper_function_select_b;

   ////////////////////////////////////////////////////////////////////////////
   // Pin mux, one slice per pin; index 0 is pin 16, index 7 is pin 23.

   for (genvar i = 0; i < NUM_PINS; i++)
   begin : g_pin
      logic [pfs_pkg::FIELD_W-1:0] pin_field;

      // Field i steers pin 16+i; serial direction per pin from the map.
      assign pin_field = field_of(port_e_upper_function_select_b, i); // [R11]
      pfs_pin_route #(
         .SER_DIR(pfs_pkg::SER_DIR_MAP[i*2 +: 2])
      ) u_route (
         .route(pin_field), // [R2] [R3] [R4] [R5] [R6] [R7] [R8] [R9]
         .pad_in(pad_in[i]),
         .pad_out(pad_out[i]),
         .pad_oe(pad_oe[i]),
         .gpio_out(gpio_out[i]),
         .gpio_oe(gpio_oe[i]),
         .gpio_in(gpio_in[i]),
         .host_out(host_port_out[i]),
         .host_oe(host_port_oe[i]),
         .host_in(host_port_in[i]),
         .ser_out(serial_out[i]),
         .ser_oe(serial_oe[i]),
         .ser_in(serial_in[i]),
         .ebus_out(ext_bus_out[i]),
         .ebus_oe(ext_bus_oe[i]),
         .ebus_in(ext_bus_in[i])
      );
   end

endmodule : pfs_port_e_upper_mux

/* sim/pfs_properties.sv */
// Concurrent checks for the port E upper pin function select block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/10ps
module pfs_properties #(
   parameter int NUM_PINS = 8
)
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic host_boot,
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [15:0] reg_rdata,
   input wire logic [15:0] pin_route,
   input wire logic [NUM_PINS-1:0] pad_in,
   input wire logic [NUM_PINS-1:0] pad_out,
   input wire logic [NUM_PINS-1:0] pad_oe,
   input wire logic [NUM_PINS-1:0] host_port_out,
   input wire logic [NUM_PINS-1:0] serial_out,
   input wire logic [NUM_PINS-1:0] serial_in
);
////////////////////
default clocking @(posedge core_clk); endclocking
default disable iff (reset);
AST_RD: assert property (reg_read && reg_addr == 8'h00 |=> reg_rdata == $past(pin_route))
   else $error("read data differs from register");
AST_UNMAPPED: assert property (reg_read && reg_addr != 8'h00 |=> reg_rdata == 16'h0000)
   else $error("unmapped read not zero");
AST_WR: assert property (reg_write && reg_addr == 8'h00 |=> pin_route == $past(reg_wdata))
   else $error("write not taken");
AST_KEEP: assert property (!(reg_write && reg_addr == 8'h00) |=> $stable(pin_route))
   else $error("register changed without write");
AST_BOOT: assert property (disable iff (1'b0)
   reset |=> pin_route == ($past(host_boot) ? 16'h5555 : 16'h0000))
   else $error("wrong reset value");
AST_P23: assert property (pin_route[15:14] == 2'h1 |-> pad_out[7] == host_port_out[7])
   else $error("pin 23 host route wrong");
AST_P21: assert property (pin_route[11:10] == 2'h2
   |-> pad_oe[5] && pad_out[5] == serial_out[5])
   else $error("pin 21 serial route wrong");
AST_P16: assert property (pin_route[1:0] == 2'h2
   |-> !pad_oe[0] && serial_in[0] == pad_in[0])
   else $error("pin 16 serial route wrong");
cover property (reg_write && reg_addr == 8'h00);
cover property (pin_route == 16'haaaa);
cover property (reg_read && reg_addr != 8'h00);
endmodule : pfs_properties

/* sim/test_pfs_port_e_upper_mux.sv */
// Self-checking bench for the port E upper pin function select block.
// Assumes the package, design and checker are compiled first.
`timescale 1ns/10ps
module test_pfs_port_e_upper_mux;
logic core_clk = 0, reset = 1, host_boot = 0, reg_write = 0, reg_read = 0;
logic [7:0] reg_addr = 8'h00, pad_in = 8'h00, gpio_out = 8'h00, gpio_oe = 8'h00;
logic [7:0] host_port_out = 8'h00, host_port_oe = 8'h00, serial_out = 8'h00;
logic [7:0] serial_oe = 8'h00, ext_bus_out = 8'h00, ext_bus_oe = 8'h00;
logic [7:0] pad_out, pad_oe, gpio_in, host_port_in, serial_in, ext_bus_in;
logic [15:0] reg_wdata = 16'h0000, reg_rdata, pin_route;
logic [7:0] x_out[4] = '{8'h11, 8'h33, 8'h3c, 8'h77};
logic [7:0] x_oe[4] = '{8'h22, 8'h44, 8'h3c, 8'h88};
logic [31:0] x_in[4] = '{32'h99000000, 32'h00990000, 32'h00009100, 32'h00000099};
int err_count = 0, checks_done = 0;
pfs_port_e_upper_mux u_dut (.core_clk, .reset, .host_boot, .reg_addr, .reg_wdata,
   .reg_write, .reg_read, .reg_rdata, .pin_route, .pad_in, .pad_out, .pad_oe, .gpio_out,
   .gpio_oe, .gpio_in, .host_port_out, .host_port_oe, .host_port_in, .serial_out,
   .serial_oe, .serial_in, .ext_bus_out, .ext_bus_oe, .ext_bus_in);
initial forever #25 core_clk = ~core_clk;
////////////////////
task automatic chk(input logic [15:0] got, input logic [15:0] exp);
   checks_done++;
   if (got !== exp)
   begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
   end
endtask : chk
task automatic wr(input logic [7:0] a, input logic [15:0] d);
   @(posedge core_clk);
   reg_addr <= a;
   reg_wdata <= d;
   reg_write <= 1'b1;
   @(posedge core_clk);
   reg_write <= 1'b0;
endtask : wr
task automatic rd(input logic [7:0] a, input logic [15:0] exp);
   @(posedge core_clk);
   reg_addr <= a;
   reg_read <= 1'b1;
   @(posedge core_clk);
   reg_read <= 1'b0;
   #1 chk(reg_rdata, exp);
endtask : rd
task automatic test_done();
   if (err_count == 0 && checks_done > 0)
      $display("Testbench passed");
   else
      $display("Testbench failed");
   $finish;
endtask : test_done
////////////////////
task automatic t_boot(input logic hb);
   @(posedge core_clk);
   reset <= 1'b1;
   host_boot <= hb;
   repeat (20) @(posedge core_clk);
   reset <= 1'b0;
   rd(8'h00, hb ? 16'h5555 : 16'h0000);
   if (hb)
      chk({pad_out, pad_oe}, {8'h33, 8'h44});
endtask : t_boot
task automatic t_mix();
   wr(8'h00, 16'h1b4e);
   wr(8'h04, 16'hffff);
   rd(8'h00, 16'h1b4e);
   chk(pin_route, 16'h1b4e);
   rd(8'h04, 16'h0000);
   @(posedge core_clk);
   #1 chk(reg_rdata, 16'h0000);
endtask : t_mix
task automatic t_codes();
   @(posedge core_clk);
   {gpio_out, gpio_oe, host_port_out, host_port_oe} <= 32'h11223344;
   {serial_out, serial_oe, ext_bus_out, ext_bus_oe, pad_in} <= 40'hff10778899;
   for (int c = 0; c < 4; c++)
   begin
      wr(8'h00, {8{2'(c)}});
      rd(8'h00, {8{2'(c)}});
      chk(pad_oe, x_oe[c]);
      chk(pad_out & (c == 2 ? 8'h3c : 8'hff), x_out[c]);
      chk({gpio_in, host_port_in}, x_in[c][31:16]);
      chk({serial_in, ext_bus_in}, x_in[c][15:0]);
   end
endtask : t_codes
initial
begin
   t_boot(1'b0);
   t_mix();
   t_codes();
   t_boot(1'b1);
   test_done();
end
endmodule : test_pfs_port_e_upper_mux
bind pfs_port_e_upper_mux pfs_properties #(.NUM_PINS(NUM_PINS)) u_chk (.core_clk, .reset,
   .host_boot, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .pin_route,
   .pad_in, .pad_out, .pad_oe, .host_port_out, .serial_out, .serial_in);
